//--- core/ccl_control.sv
// convolver control logic: config registers, pixel alu, cascade path
`timescale 1ns/1ps

module ccl_control
    import ccl_pkg::*;
(
    // clock and reset
    input  wire logic                         ref_clk,
    input  wire logic                         reset_n,
    // configuration pins
    input  wire logic [ccl_pkg::CCL_CFG_W-1:0] config_bus,
    input  wire logic [2:0]                    reg_addr,
    input  wire logic                          chip_sel_n,
    input  wire logic                          load_strobe_n,
    input  wire logic                          alu_load_en,
    // pixel stream
    input  wire logic [ccl_pkg::CCL_PIX_W-1:0] pixel_in,
    output logic      [ccl_pkg::CCL_PIX_W-1:0] pixel_to_array,
    input  wire logic [ccl_pkg::CCL_PIX_W-1:0] row_buf_one,
    input  wire logic [ccl_pkg::CCL_PIX_W-1:0] row_buf_two,
    output logic      [ccl_pkg::CCL_PIX_W-1:0] tap_row_one,
    output logic      [ccl_pkg::CCL_PIX_W-1:0] tap_row_two,
    // configuration towards the array
    output logic      [71:0]                   kernel_coef,
    output logic                               active_bank,
    output logic      [9:0]                    row_length,
    output logic                               pixel_signed,
    output logic                               coef_signed,
    // result stream
    input  wire logic [ccl_pkg::CCL_RES_W-1:0]   product_sum,
    input  wire logic                            product_valid,
    output logic                                 product_ready,
    input  wire logic [ccl_pkg::CCL_CHAIN_W-1:0] chain_in,
    output logic      [ccl_pkg::CCL_RES_W-1:0]   result_out,
    output logic                                 result_valid,
    input  wire logic                            result_ready
);
    import ccl_pkg::*;

    // -------------------------------------------------------------
    // pin synchronisers and strobe edge
    // -------------------------------------------------------------
    logic [CCL_CFG_W-1:0] cfg_s1_q, cfg_s2_q, hold_data_q, hold_data_d;
    logic [2:0]           adr_s1_q, adr_s2_q, hold_addr_q, hold_addr_d;
    logic                 cs_s1_q, cs_s2_q, ld_s1_q, ld_s2_q, ld_prev_q;
    logic                 ealu_s1_q, ealu_s2_q, hold_cs_q, hold_cs_d;
    logic                 wr_stb;
    ccl_addr_type         wr_addr;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_s1_q  <= '0;
            cfg_s2_q  <= '0;
            adr_s1_q  <= 3'h7;
            adr_s2_q  <= 3'h7;
            cs_s1_q   <= 1'b1;
            cs_s2_q   <= 1'b1;
            ld_s1_q   <= 1'b1;
            ld_s2_q   <= 1'b1;
            ld_prev_q <= 1'b1;
            ealu_s1_q <= 1'b0;
            ealu_s2_q <= 1'b0;
        end else begin
            cfg_s1_q  <= config_bus;
            cfg_s2_q  <= cfg_s1_q;
            adr_s1_q  <= reg_addr;
            adr_s2_q  <= adr_s1_q;
            cs_s1_q   <= chip_sel_n;
            cs_s2_q   <= cs_s1_q;
            ld_s1_q   <= load_strobe_n;
            ld_s2_q   <= ld_s1_q;
            ld_prev_q <= ld_s2_q;
            ealu_s1_q <= alu_load_en;
            ealu_s2_q <= ealu_s1_q;
        end
    end

    // last values seen while the strobe was low
    always_comb begin
        hold_data_d = hold_data_q;
        hold_addr_d = hold_addr_q;
        hold_cs_d   = hold_cs_q;
        if (!ld_s2_q) begin
            hold_data_d = cfg_s2_q;
            hold_addr_d = adr_s2_q;
            hold_cs_d   = !cs_s2_q;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            hold_data_q <= '0;
            hold_addr_q <= 3'h7;
            hold_cs_q   <= 1'b0;
        end else begin
            hold_data_q <= hold_data_d;
            hold_addr_q <= hold_addr_d;
            hold_cs_q   <= hold_cs_d;
        end
    end

    assign wr_stb  = ld_s2_q && !ld_prev_q && hold_cs_q;
    assign wr_addr = ccl_addr_type'(hold_addr_q);

    // -------------------------------------------------------------
    // configuration registers and coefficient banks
    // -------------------------------------------------------------
    logic [9:0] row_len_q, row_len_d, opcode_q, opcode_d;
    logic [8:0] setup_q, setup_d;
    logic [7:0] alu_b_q, alu_b_d;
    logic [7:0] bank0_q [CCL_TAPS], bank0_d [CCL_TAPS];
    logic [7:0] bank1_q [CCL_TAPS], bank1_d [CCL_TAPS];
    logic [3:0] idx0_q, idx0_d, idx1_q, idx1_d;
    logic       act_q, act_d;
    logic [71:0] coef_q, coef_d;

    always_comb begin
        row_len_d = row_len_q;
        opcode_d  = opcode_q;
        setup_d   = setup_q;
        alu_b_d   = ealu_s2_q ? cfg_s2_q[7:0] : alu_b_q;
        bank0_d   = bank0_q;
        bank1_d   = bank1_q;
        idx0_d    = idx0_q;
        idx1_d    = idx1_q;
        act_d     = act_q;
        if (wr_stb) begin
            if (wr_addr == CCL_ADDR_ROW_LENGTH) begin
                row_len_d = hold_data_q;
            end else if (wr_addr == CCL_ADDR_ALU_OPCODE) begin
                opcode_d = hold_data_q;
            end else if (wr_addr == CCL_ADDR_BANK_ZERO) begin
                bank0_d[idx0_q] = hold_data_q[7:0];
                idx0_d = (idx0_q == CCL_LAST_TAP) ? 4'h0 : idx0_q + 4'h1;
            end else if (wr_addr == CCL_ADDR_BANK_ONE) begin
                bank1_d[idx1_q] = hold_data_q[7:0];
                idx1_d = (idx1_q == CCL_LAST_TAP) ? 4'h0 : idx1_q + 4'h1;
            end else if (wr_addr == CCL_ADDR_SETUP) begin
                setup_d = hold_data_q[8:0];
            end else if (wr_addr == CCL_ADDR_SEL_ZERO) begin
                act_d = 1'b0;
            end else if (wr_addr == CCL_ADDR_SEL_ONE) begin
                act_d = 1'b1;
            end
        end
        for (int i = 0; i < CCL_TAPS; i++) begin
            coef_d[i*8 +: 8] = act_d ? bank1_d[i] : bank0_d[i];
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            row_len_q <= CCL_ROW_LEN_RST;
            opcode_q  <= CCL_OPCODE_RST;
            setup_q   <= CCL_SETUP_RST;
            alu_b_q   <= CCL_ALU_B_RST;
            bank0_q   <= '{default: 8'h00};
            bank1_q   <= '{default: 8'h00};
            idx0_q    <= 4'h0;
            idx1_q    <= 4'h0;
            act_q     <= 1'b0;
            coef_q    <= '0;
        end else begin
            row_len_q <= row_len_d;
            opcode_q  <= opcode_d;
            setup_q   <= setup_d;
            alu_b_q   <= alu_b_d;
            bank0_q   <= bank0_d;
            bank1_q   <= bank1_d;
            idx0_q    <= idx0_d;
            idx1_q    <= idx1_d;
            act_q     <= act_d;
            coef_q    <= coef_d;
        end
    end

    // -------------------------------------------------------------
    // pixel alu, shifter and input delay
    // -------------------------------------------------------------
    logic [7:0] alu_res, shift_res, pix_q, pix_d;
    logic [7:0] dly_q [4], dly_d [4];
    logic [7:0] tap1_q, tap1_d, tap2_q, tap2_d;
    logic [1:0] dsel;

    always_comb begin
        alu_res = '0;
        if (opcode_q[2:0] == CCL_OP_ADD) begin
            alu_res = pixel_in + alu_b_q;
        end else if (opcode_q[2:0] == CCL_OP_SUB_AB) begin
            alu_res = pixel_in - alu_b_q;
        end else if (opcode_q[2:0] == CCL_OP_SUB_BA) begin
            alu_res = alu_b_q - pixel_in;
        end else begin
            // truth table indexed by the inverted operand bit pair {!pixel_in, !alu_b_q}
            for (int i = 0; i < CCL_PIX_W; i++) begin
                alu_res[i] = opcode_q[CCL_OP_LOGIC_LSB
                                      + {!pixel_in[i], !alu_b_q[i]}];
            end
        end
        shift_res = alu_res;
        if (opcode_q[9:7] != CCL_SH_NONE
            && opcode_q[9:7] <= CCL_SH_RIGHT3) begin
            shift_res = alu_res >> opcode_q[8:7];
        end else if (opcode_q[9:7] > CCL_SH_RIGHT3
                     && opcode_q[9:7] <= CCL_SH_LEFT3) begin
            shift_res = alu_res << (opcode_q[8:7] + 2'h1);
        end
        dly_d[0] = shift_res;
        for (int i = 1; i < 4; i++) begin
            dly_d[i] = dly_q[i-1];
        end
        dsel  = setup_q[CCL_SU_DELAY_LSB +: 2];
        pix_d = dly_d[dsel];
        tap1_d = row_buf_one;
        tap2_d = row_buf_two;
        if (setup_q[CCL_SU_CASCADE]) begin
            tap1_d = chain_in[15:8];
            tap2_d = chain_in[7:0];
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            dly_q  <= '{default: 8'h00};
            pix_q  <= '0;
            tap1_q <= '0;
            tap2_q <= '0;
        end else begin
            dly_q  <= dly_d;
            pix_q  <= pix_d;
            tap1_q <= tap1_d;
            tap2_q <= tap2_d;
        end
    end

    // -------------------------------------------------------------
    // cascade sum, rounding and two-entry result buffer
    // -------------------------------------------------------------
    logic [19:0] chain_sh, sum, rnd;
    logic [19:0] ent0_q, ent0_d, ent1_q, ent1_d;
    logic [1:0]  cnt_q, cnt_d;
    logic        push, pop, rdy_q, rdy_d, vld_q, vld_d;

    always_comb begin
        chain_sh = 20'(chain_in);
        case (setup_q[CCL_SU_SHIFT_LSB +: 2])
            2'h1:    chain_sh = 20'(chain_in) << 2;
            2'h2:    chain_sh = 20'(chain_in) << 4;
            2'h3:    chain_sh = 20'(chain_in) << 8;
            default: chain_sh = 20'(chain_in);
        endcase
        sum = setup_q[CCL_SU_CASCADE] ? product_sum
                                      : product_sum + chain_sh;
        rnd = sum;
        if (setup_q[CCL_SU_ROUND_LSB +: 2] == CCL_RND_16) begin
            rnd = (sum + CCL_RND_16_HALF) & CCL_RND_16_MASK;
        end else if (setup_q[CCL_SU_ROUND_LSB +: 2] == CCL_RND_8) begin
            rnd = (sum + CCL_RND_8_HALF) & CCL_RND_8_MASK;
        end
        push   = product_valid && rdy_q;
        pop    = vld_q && result_ready;
        ent0_d = ent0_q;
        ent1_d = ent1_q;
        cnt_d  = cnt_q;
        if (pop) begin
            ent0_d = ent1_q;
            cnt_d  = cnt_d - 2'h1;
        end
        if (push) begin
            if (cnt_d == 2'h0) begin
                ent0_d = rnd;
            end else begin
                ent1_d = rnd;
            end
            cnt_d = cnt_d + 2'h1;
        end
        rdy_d = (cnt_d != 2'h2);
        vld_d = (cnt_d != 2'h0);
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ent0_q <= '0;
            ent1_q <= '0;
            cnt_q  <= 2'h0;
            rdy_q  <= 1'b1;
            vld_q  <= 1'b0;
        end else begin
            ent0_q <= ent0_d;
            ent1_q <= ent1_d;
            cnt_q  <= cnt_d;
            rdy_q  <= rdy_d;
            vld_q  <= vld_d;
        end
    end

    assign pixel_to_array = pix_q;
    assign tap_row_one    = tap1_q;
    assign tap_row_two    = tap2_q;
    assign kernel_coef    = coef_q;
    assign active_bank    = act_q;
    assign row_length     = row_len_q;
    assign pixel_signed   = setup_q[CCL_SU_PIX_FMT];
    assign coef_signed    = setup_q[CCL_SU_COEF_FMT];
    assign product_ready  = rdy_q;
    assign result_out     = ent0_q;
    assign result_valid   = vld_q;

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence s_strobe_rise;
        !ld_s2_q ##1 ld_s2_q;
    endsequence

    a_opcode_capture: assert property (
        (wr_stb && wr_addr == CCL_ADDR_ALU_OPCODE) |=> opcode_q == $past(hold_data_q))
        else $error("opcode not captured at strobe end");
    a_bank_one_sel: assert property (
        (s_strobe_rise ##0 (hold_cs_q && hold_addr_q == 3'h6))
        |=> act_q ##1 coef_q[7:0] == bank1_q[0])
        else $error("bank one not selected");
    a_inactive_load: assert property (
        (wr_stb && wr_addr == CCL_ADDR_BANK_ZERO && act_q) |=> $stable(coef_q))
        else $error("active coefficients disturbed");
    a_nop_stable: assert property (
        (wr_stb && wr_addr == CCL_ADDR_NOP)
        |=> $stable(opcode_q) && $stable(setup_q) && $stable(act_q))
        else $error("no-operation code changed state");
    a_index_wrap: assert property (
        (wr_stb && wr_addr == CCL_ADDR_BANK_ONE && idx1_q == CCL_LAST_TAP)
        |=> idx1_q == 4'h0)
        else $error("coefficient index did not restart");
    a_alu_pass: assert property (
        (opcode_q == CCL_OPCODE_RST && setup_q[2:1] == 2'h0) |=> pix_q == $past(pixel_in))
        else $error("logical A did not pass pixel");
    a_chain_split: assert property (
        setup_q[CCL_SU_CASCADE] |=> tap1_q == $past(chain_in[15:8])
                                    && tap2_q == $past(chain_in[7:0]))
        else $error("chain bytes not fed to taps");
    a_buffer_full: assert property (
        (cnt_q == 2'h2) |-> !rdy_q && vld_q)
        else $error("full buffer still accepting");
    a_add_op: assert property (
        (opcode_q[2:0] == CCL_OP_ADD && opcode_q[9:7] == 3'h0 && dsel == 2'h0)
        |=> pix_q == 8'($past(pixel_in) + $past(alu_b_q)))
        else $error("add opcode wrong");

endmodule : ccl_control

//--- core/ccl_pkg.sv
// constants and types of the convolver control logic
package ccl_pkg;

    // -------------------------------------------------------------
    // register addresses on reg_addr
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        CCL_ADDR_ROW_LENGTH = 3'h0,
        CCL_ADDR_ALU_OPCODE = 3'h1,
        CCL_ADDR_BANK_ZERO  = 3'h2,
        CCL_ADDR_BANK_ONE   = 3'h3,
        CCL_ADDR_SETUP      = 3'h4,
        CCL_ADDR_SEL_ZERO   = 3'h5,
        CCL_ADDR_SEL_ONE    = 3'h6,
        CCL_ADDR_NOP        = 3'h7
    } ccl_addr_type;

    // -------------------------------------------------------------
    // widths and reset values
    // -------------------------------------------------------------
    localparam int          CCL_PIX_W        = 8;
    localparam int          CCL_CFG_W        = 10;
    localparam int          CCL_RES_W        = 20;
    localparam int          CCL_CHAIN_W      = 16;
    localparam int          CCL_TAPS         = 9;
    localparam logic [3:0]  CCL_LAST_TAP     = 4'h8;
    localparam logic [9:0]  CCL_ROW_LEN_RST  = 10'h000;
    localparam logic [9:0]  CCL_OPCODE_RST   = 10'h018;
    localparam logic [8:0]  CCL_SETUP_RST    = 9'h000;
    localparam logic [7:0]  CCL_ALU_B_RST    = 8'h00;

    // -------------------------------------------------------------
    // opcode fields
    // -------------------------------------------------------------
    localparam int          CCL_OP_LOGIC_LSB = 3;
    localparam logic [2:0]  CCL_OP_ADD       = 3'h1;
    localparam logic [2:0]  CCL_OP_SUB_AB    = 3'h2;
    localparam logic [2:0]  CCL_OP_SUB_BA    = 3'h4;
    localparam logic [2:0]  CCL_SH_NONE      = 3'h0;
    localparam logic [2:0]  CCL_SH_RIGHT3    = 3'h3;
    localparam logic [2:0]  CCL_SH_LEFT3     = 3'h6;

    // -------------------------------------------------------------
    // setup word fields
    // -------------------------------------------------------------
    localparam int          CCL_SU_CASCADE   = 0;
    localparam int          CCL_SU_DELAY_LSB = 1;
    localparam int          CCL_SU_PIX_FMT   = 3;
    localparam int          CCL_SU_COEF_FMT  = 4;
    localparam int          CCL_SU_ROUND_LSB = 5;
    localparam int          CCL_SU_SHIFT_LSB = 7;
    localparam logic [1:0]  CCL_RND_16       = 2'h1;
    localparam logic [1:0]  CCL_RND_8        = 2'h2;
    localparam logic [19:0] CCL_RND_16_HALF  = 20'h00008;
    localparam logic [19:0] CCL_RND_16_MASK  = 20'hffff0;
    localparam logic [19:0] CCL_RND_8_HALF   = 20'h00800;
    localparam logic [19:0] CCL_RND_8_MASK   = 20'hff000;

endpackage : ccl_pkg

//--- dv/ccl_result_sink.sv
// result sink model on the far side of the output stream
`timescale 1ns/1ps

module ccl_result_sink
    import ccl_pkg::*;
(
    // clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          reset_n,
    // stream from the block
    input  wire logic [ccl_pkg::CCL_RES_W-1:0] result_out,
    input  wire logic                          result_valid,
    output logic                               result_ready,
    // stall request from the bench
    input  wire logic                          stall
);
    logic [CCL_RES_W-1:0] got [$];

    // ready drops while stalled, so the block must hold its word
    assign result_ready = ~stall;

    always @(posedge ref_clk) begin
        if (reset_n && result_valid && result_ready) begin
            got.push_back(result_out);
        end
    end
endmodule : ccl_result_sink

//--- dv/ccl_control_tb.sv
// self-checking bench of the convolver control logic
`timescale 1ns/1ps

module ccl_control_tb;
    import ccl_pkg::*;

    typedef struct packed {
        logic [9:0]  op;
        logic [8:0]  setup;
        logic [15:0] chain;
        logic [19:0] sum;
        logic [7:0]  exp_pix;
        logic [19:0] exp_res;
    } ccl_row_type;

    logic        ref_clk       = 1'b0;
    logic        reset_n       = 1'b0;
    logic [9:0]  config_bus    = 10'h000;
    logic [2:0]  reg_addr      = 3'h7;
    logic        chip_sel_n    = 1'b1;
    logic        load_strobe_n = 1'b1;
    logic        alu_load_en   = 1'b0;
    logic [7:0]  pixel_in      = 8'h0c;
    logic [7:0]  row_buf_one   = 8'h11;
    logic [7:0]  row_buf_two   = 8'h22;
    logic [19:0] product_sum   = 20'h00000;
    logic        product_valid = 1'b0;
    logic [15:0] chain_in      = 16'h0000;
    logic        stall         = 1'b0;
    logic [7:0]  pixel_to_array, tap_row_one, tap_row_two;
    logic [71:0] kernel_coef, e0, e1;
    logic        active_bank, pixel_signed, coef_signed;
    logic        product_ready, result_valid, result_ready;
    logic [9:0]  row_length;
    logic [19:0] result_out;
    int          errors        = 0;
    int          total_checks  = 0;
    int          n0, n3;
    ccl_row_type rows [17];

    always #2 ref_clk = ~ref_clk;

    ccl_control DUT (.ref_clk, .reset_n, .config_bus, .reg_addr,
        .chip_sel_n, .load_strobe_n, .alu_load_en, .pixel_in,
        .pixel_to_array, .row_buf_one, .row_buf_two, .tap_row_one,
        .tap_row_two, .kernel_coef, .active_bank, .row_length,
        .pixel_signed, .coef_signed, .product_sum, .product_valid,
        .product_ready, .chain_in, .result_out, .result_valid,
        .result_ready);

    ccl_result_sink sink (.ref_clk, .reset_n, .result_out,
        .result_valid, .result_ready, .stall);

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [71:0] seen, input logic [71:0] exp,
                       input string what);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: %s seen %h expected %h",
                     $time, what, seen, exp);
        end
    endtask : chk

    task automatic ran_out();
        errors++;
        $display("wrong value at %0t: wait ran out", $time);
        tally_and_finish();
    endtask : ran_out

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc

    task automatic wr(input logic [2:0] a, input logic [9:0] d,
                      input logic cs_n);
        @(negedge ref_clk);
        reg_addr = a;
        config_bus = d;
        chip_sel_n = cs_n;
        cyc(2);
        load_strobe_n = 1'b0;
        cyc(3);
        load_strobe_n = 1'b1;
        cyc(8);
        chip_sel_n = 1'b1;
        reg_addr = 3'h7;
    endtask : wr

    task automatic push(input logic [19:0] s);
        int i;
        @(negedge ref_clk);
        product_sum = s;
        product_valid = 1'b1;
        for (i = 0; i < 50 && product_ready !== 1'b1; i++) begin
            @(negedge ref_clk);
        end
        if (i == 50) begin
            ran_out();
        end
        @(negedge ref_clk);
        product_valid = 1'b0;
    endtask : push

    task automatic wait_words(input int n);
        int i;
        for (i = 0; i < 50 && sink.got.size() < n; i++) begin
            @(negedge ref_clk);
        end
        if (i == 50) begin
            ran_out();
        end
    endtask : wait_words

    task automatic lat(input logic [7:0] v, output int n);
        @(negedge ref_clk);
        pixel_in = v;
        for (n = 0; n < 20 && pixel_to_array !== v; n++) begin
            @(negedge ref_clk);
        end
        if (n == 20) begin
            ran_out();
        end
    endtask : lat

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        int k;
        rows = '{
            '{10'h018, 9'h000, 16'h0001, 20'h00010, 8'h0c, 20'h00011},
            '{10'h000, 9'h080, 16'h0003, 20'h00100, 8'h00, 20'h0010c},
            '{10'h078, 9'h100, 16'h0003, 20'h00000, 8'hff, 20'h00030},
            '{10'h028, 9'h180, 16'h00ff, 20'h00001, 8'h0a, 20'h0ff01},
            '{10'h060, 9'h020, 16'h0000, 20'h00018, 8'hf3, 20'h00020},
            '{10'h050, 9'h040, 16'h0000, 20'h00800, 8'hf5, 20'h01000},
            '{10'h008, 9'h008, 16'h0000, 20'h12345, 8'h08, 20'h12345},
            '{10'h038, 9'h010, 16'h0000, 20'hfffff, 8'h0e, 20'hfffff},
            '{10'h070, 9'h018, 16'h0000, 20'h00000, 8'hf7, 20'h00000},
            '{10'h040, 9'h000, 16'h0000, 20'h00001, 8'hf1, 20'h00001},
            '{10'h030, 9'h000, 16'h0000, 20'h00002, 8'h06, 20'h00002},
            '{10'h048, 9'h000, 16'h0000, 20'h00003, 8'hf9, 20'h00003},
            '{10'h031, 9'h000, 16'h0000, 20'h00004, 8'h16, 20'h00004},
            '{10'h04a, 9'h000, 16'h0000, 20'h00005, 8'h02, 20'h00005},
            '{10'h04c, 9'h000, 16'h0000, 20'h00006, 8'hfe, 20'h00006},
            '{10'h098, 9'h000, 16'h0000, 20'h00007, 8'h06, 20'h00007},
            '{10'h318, 9'h000, 16'h0000, 20'h00008, 8'h60, 20'h00008}};
        cyc(16);
        reset_n = 1'b1;
        cyc(4);
        chk(row_length, 10'h000, "row length at reset");
        chk(kernel_coef, 72'h0, "taps at reset");
        chk({active_bank, product_ready, result_valid}, 3'b010,
            "flags at reset");
        // operand b stays 0x0a for the whole table
        @(negedge ref_clk);
        config_bus = 10'h00a;
        alu_load_en = 1'b1;
        cyc(4);
        alu_load_en = 1'b0;
        for (k = 0; k < 17; k++) begin
            wr(3'h1, rows[k].op, 1'b0);
            wr(3'h4, {1'b0, rows[k].setup}, 1'b0);
            chain_in = rows[k].chain;
            cyc(8);
            chk(pixel_to_array, rows[k].exp_pix, "pixel alu");
            chk({pixel_signed, coef_signed},
                {rows[k].setup[3], rows[k].setup[4]}, "formats");
            push(rows[k].sum);
            wait_words(k + 1);
            chk(sink.got[k], rows[k].exp_res, "result");
        end
        $display("table rows done");

        // ---------------------------------------------------------------
        // hand-written cases
        // ---------------------------------------------------------------
        @(negedge ref_clk);
        reg_addr = 3'h0;
        config_bus = 10'h3ff;
        chip_sel_n = 1'b0;
        cyc(2);
        load_strobe_n = 1'b0;
        cyc(10);
        chk(row_length, 10'h000, "taken before strobe rise");
        load_strobe_n = 1'b1;
        cyc(8);
        chk(row_length, 10'h3ff, "row length write");
        wr(3'h0, 10'h155, 1'b1);
        chk(row_length, 10'h3ff, "write without select");
        $display("strobe and select done");
        for (k = 0; k < 9; k++) begin
            wr(3'h3, 10'(8'h11 * (k + 1)), 1'b0);
            e1[k*8 +: 8] = 8'(8'h11 * (k + 1));
        end
        chk(kernel_coef, 72'h0, "inactive bank load");
        wr(3'h6, 10'h000, 1'b0);
        chk(active_bank, 1'b1, "select bank one");
        chk(kernel_coef, e1, "bank one taps");
        for (k = 0; k < 9; k++) begin
            wr(3'h2, 10'(k + 1), 1'b0);
            e0[k*8 +: 8] = 8'(k + 1);
        end
        chk(kernel_coef, e1, "bank one kept");
        wr(3'h5, 10'h000, 1'b0);
        chk(active_bank, 1'b0, "select bank zero");
        chk(kernel_coef, e0, "bank zero taps");
        wr(3'h2, 10'h0ee, 1'b0);
        e0[7:0] = 8'hee;
        chk(kernel_coef, e0, "tenth write wraps");
        wr(3'h7, 10'h2aa, 1'b0);
        chk(kernel_coef, e0, "no operation taps");
        chk(row_length, 10'h3ff, "no operation row");
        $display("banks done");
        wr(3'h1, 10'h018, 1'b0);
        wr(3'h4, 10'h006, 1'b0);
        lat(8'h5a, n3);
        wr(3'h4, 10'h000, 1'b0);
        lat(8'ha5, n0);
        chk(n3 - n0, 3, "extra input delays");
        wr(3'h4, 10'h001, 1'b0);
        chain_in = 16'ha55a;
        cyc(4);
        chk({tap_row_one, tap_row_two}, 16'ha55a, "chain taps");
        wr(3'h4, 10'h000, 1'b0);
        chk({tap_row_one, tap_row_two}, 16'h1122, "row buffer taps");
        $display("delay and cascade done");
        chain_in = 16'h0000;
        stall = 1'b1;
        push(20'h00aa1);
        push(20'h00aa2);
        cyc(2);
        chk({product_ready, result_valid}, 2'b01, "buffer full refuses");
        cyc(6);
        stall = 1'b0;
        push(20'h00aa3);
        wait_words(20);
        chk(sink.got[17], 20'h00aa1, "first word order");
        chk(sink.got[18], 20'h00aa2, "middle word order");
        chk(sink.got[19], 20'h00aa3, "last word order");
        $display("buffer done");
        @(negedge ref_clk);
        reset_n = 1'b0;
        cyc(2);
        chk(row_length, 10'h000, "row length after reset");
        chk(kernel_coef, 72'h0, "taps after reset");
        chk({active_bank, product_ready, result_valid}, 3'b010,
            "flags after reset");
        reset_n = 1'b1;
        cyc(4);
        $display("second reset done");
        tally_and_finish();
    end
endmodule : ccl_control_tb
